// File: hw/wsc_map.svh
// Addresses, reset values, masks and field positions of the wake source configuration registers
`ifndef WSC_MAP_SVH
`define WSC_MAP_SVH
`define WSC_ADDR_INT      7'h06
`define WSC_ADDR_EXT      7'h07
`define WSC_ADDR_PULL     7'h08
`define WSC_RST_INT       8'h00
`define WSC_RST_EXT       8'h07
`define WSC_RST_PULL      8'h00
`define WSC_WMASK_INT     8'hc4
`define WSC_WMASK_EXT     8'ha7
`define WSC_WMASK_PULL    8'h3f
`define WSC_RESTART_KEEP  8'ha7
`define WSC_FS_KEEP_EXT   8'ha0
`define WSC_FS_SET_EXT    8'h07
`define WSC_BIT_T2_WAKE   7
`define WSC_BIT_T1_WAKE   6
`define WSC_BIT_WD_HI     2
`define WSC_BIT_GLOBAL    7
`define WSC_BIT_MEAS      5
`define WSC_BIT_C_WAKE    2
`define WSC_BIT_B_WAKE    1
`define WSC_BIT_A_WAKE    0
`define WSC_POS_C_PULL    4
`define WSC_POS_B_PULL    2
`define WSC_POS_A_PULL    0
`define WSC_FRAME_BITS    5'd16
`define WSC_HDR_BITS      5'd8
`define WSC_MODE_WAKE     2'h1
`endif

// File: hw/wsc_pkg.sv
// Types shared by the wake source configuration block
package wsc_pkg;
  // Pull configuration of one wake input
  typedef enum logic [1:0] {
    WSC_PULL_NONE = 2'h0,
    WSC_PULL_DOWN = 2'h1,
    WSC_PULL_UP   = 2'h2,
    WSC_PULL_AUTO = 2'h3
  } wsc_pull_t;
  // Serial frame receiver states, Gray coded
  typedef enum logic [1:0] {
    WSC_SP_IDLE  = 2'h0,
    WSC_SP_SHIFT = 2'h1,
    WSC_SP_OVER  = 2'h3
  } wsc_spi_st_t;
endpackage

// File: hw/wsc_spi_frame.sv
// Serial control port frame receiver and read data shifter
`timescale 1ns/1ps
`include "wsc_map.svh"
module wsc_spi_frame import wsc_pkg::*; (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic       sclk,
  input  wire logic       sdi,
  input  wire logic       serial_chip_select_n,
  input  wire logic [7:0] rd_data,
  output logic [6:0]      hdr_addr,
  output logic            sdo,
  output logic            sdo_oe,
  output logic            frm_valid,
  output logic [6:0]      frm_addr,
  output logic            frm_wr,
  output logic [7:0]      frm_data
);
  wsc_spi_st_t st_q, st_d;      // Frame state
  logic [4:0]  cnt_q, cnt_d;    // Bits received
  logic [15:0] rx_q, rx_d;      // Received bits, first bit ends at bit 0
  logic [7:0]  tx_q, tx_d;      // Read data being shifted out
  logic        sck_q, cs_q;     // Previous pin levels
  logic        vld_d, oe_d;
  logic        rise, fall, cs_end;

  // Edge detection on the sampled pins
  assign rise   = sclk & ~sck_q & ~serial_chip_select_n;
  assign fall   = ~sclk & sck_q & ~serial_chip_select_n;
  assign cs_end = serial_chip_select_n & ~cs_q;
  assign hdr_addr = rx_q[14:8];

  ////////////////////////////////////////////////////////////////////////////////
  // Next state of the frame receiver
  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    rx_d  = rx_q;
    tx_d  = tx_q;
    vld_d = 1'b0;
    oe_d  = ~serial_chip_select_n;
    unique case (st_q)
      WSC_SP_IDLE: begin
        // Frame opens on chip select falling
        if (!serial_chip_select_n) begin
          st_d  = WSC_SP_SHIFT;
          cnt_d = 5'd0;
          tx_d  = 8'h00;
        end
      end
      WSC_SP_SHIFT: begin
        if (cs_end) begin
          // Only a frame of exactly full length is accepted
          vld_d = (cnt_q == `WSC_FRAME_BITS);
          st_d  = WSC_SP_IDLE;
        end else if (rise) begin
          rx_d  = {sdi, rx_q[15:1]};
          cnt_d = cnt_q + 5'd1;
          if (cnt_q == `WSC_FRAME_BITS) begin
            st_d = WSC_SP_OVER;
          end
        end else if (fall) begin
          // Header complete: load read data, else shift
          if (cnt_q == `WSC_HDR_BITS) begin
            tx_d = rd_data;
          end else begin
            tx_d = {1'b0, tx_q[7:1]};
          end
        end
      end
      WSC_SP_OVER: begin
        // Overlong frame is dropped
        if (cs_end) begin
          st_d = WSC_SP_IDLE;
        end
      end
      default: begin
        st_d = WSC_SP_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers of the frame receiver
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q      <= WSC_SP_IDLE;
      cnt_q     <= 5'd0;
      rx_q      <= 16'h0000;
      tx_q      <= 8'h00;
      sck_q     <= 1'b0;
      cs_q      <= 1'b1;
      frm_valid <= 1'b0;
      frm_addr  <= 7'h00;
      frm_wr    <= 1'b0;
      frm_data  <= 8'h00;
      sdo       <= 1'b0;
      sdo_oe    <= 1'b0;
    end else if (ce) begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      rx_q      <= rx_d;
      tx_q      <= tx_d;
      sck_q     <= sclk;
      cs_q      <= serial_chip_select_n;
      frm_valid <= vld_d;
      frm_addr  <= rx_q[6:0];
      frm_wr    <= rx_q[7];
      frm_data  <= rx_q[15:8];
      sdo       <= tx_d[0];
      sdo_oe    <= oe_d;
    end
  end
endmodule // wsc_spi_frame

// File: hw/wsc_regs.sv
// Wake source configuration register bank behind the serial control port
`timescale 1ns/1ps
`include "wsc_map.svh"
module wsc_regs import wsc_pkg::*; (
  input  wire logic       mclk,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic       soft_reset,
  input  wire logic       restart_entry,
  input  wire logic       fail_safe_entry,
  input  wire logic       normal_mode,
  input  wire logic       stop_watchdog_disable_lo,
  input  wire logic       hw_stop_wd_upd,
  input  wire logic       hw_stop_wd_val,
  input  wire logic       wake_event,
  input  wire logic       status_event,
  input  wire logic [1:0] can_mode,
  input  wire logic [1:0] lin_mode,
  input  wire logic       sclk,
  input  wire logic       sdi,
  input  wire logic       serial_chip_select_n,
  output logic            sdo,
  output logic            sdo_oe,
  output logic            second_timer_wake_enable,
  output logic            first_timer_wake_enable,
  output logic            input_a_wake_enable,
  output logic            input_b_wake_enable,
  output logic            input_c_wake_enable,
  output logic            measure_active,
  output logic            input_ab_level_ignore,
  output wsc_pull_t       input_a_pull_select,
  output wsc_pull_t       input_b_pull_select,
  output wsc_pull_t       input_c_pull_select,
  output logic            stop_watchdog_off,
  output logic            int_req,
  output logic            bus_fail_safe_force,
  output logic            can_wake_source,
  output logic            lin_wake_source
);
  logic [7:0] int_q, int_d;     // internal_wake_control
  logic [7:0] ext_q, ext_d;     // external_wake_source_control
  logic [7:0] pull_q, pull_d;   // wake_input_pull_control
  logic [7:0] rd_data;          // Read data for the addressed register
  logic [6:0] hdr_addr;         // Address of the frame in flight
  logic       frm_valid;        // Completed frame pulse
  logic [6:0] frm_addr;
  logic       frm_wr;
  logic [7:0] frm_data;
  logic       wr_ok;            // Accepted write

  ////////////////////////////////////////////////////////////////////////////////
  // Serial port
  wsc_spi_frame u_frame (
    .mclk                 (mclk),
    .nrst                 (nrst),
    .ce                   (ce),
    .sclk                 (sclk),
    .sdi                  (sdi),
    .serial_chip_select_n (serial_chip_select_n),
    .rd_data              (rd_data),
    .hdr_addr             (hdr_addr),
    .sdo                  (sdo),
    .sdo_oe               (sdo_oe),
    .frm_valid            (frm_valid),
    .frm_addr             (frm_addr),
    .frm_wr               (frm_wr),
    .frm_data             (frm_data)
  );

  // Read mux; unmapped addresses read zero
  always_comb begin
    unique case (hdr_addr)
      `WSC_ADDR_INT:  rd_data = int_q;
      `WSC_ADDR_EXT:  rd_data = ext_q;
      `WSC_ADDR_PULL: rd_data = pull_q;
      default:        rd_data = 8'h00;
    endcase
  end

  assign wr_ok = frm_valid & frm_wr;

  ////////////////////////////////////////////////////////////////////////////////
  // Register next values
  always_comb begin
    int_d  = int_q;
    ext_d  = ext_q;
    pull_d = pull_q;
    if (soft_reset) begin
      // Soft reset returns the power-on values
      int_d  = `WSC_RST_INT;
      ext_d  = `WSC_RST_EXT;
      pull_d = `WSC_RST_PULL;
    end else begin
      // Software write, reserved bits masked off
      if (wr_ok && frm_addr == `WSC_ADDR_INT) begin
        int_d = frm_data & `WSC_WMASK_INT;
      end
      if (wr_ok && frm_addr == `WSC_ADDR_EXT) begin
        ext_d = frm_data & `WSC_WMASK_EXT;
      end
      if (wr_ok && frm_addr == `WSC_ADDR_PULL) begin
        pull_d = frm_data & `WSC_WMASK_PULL;
      end
      // Hardware update wins over a write in the same cycle
      if (hw_stop_wd_upd) begin
        int_d[`WSC_BIT_WD_HI] = hw_stop_wd_val;
      end
      // Restart clears bits 6, 4, 3
      if (restart_entry) begin
        ext_d = ext_d & `WSC_RESTART_KEEP;
      end
      // Fail-safe sets the three input wake bits and keeps bits 7 and 5
      if (fail_safe_entry) begin
        ext_d = (ext_d & `WSC_FS_KEEP_EXT) | `WSC_FS_SET_EXT;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      int_q  <= `WSC_RST_INT;
      ext_q  <= `WSC_RST_EXT;
      pull_q <= `WSC_RST_PULL;
    end else if (ce) begin
      int_q  <= int_d;
      ext_q  <= ext_d;
      pull_q <= pull_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decoded controls, registered from the next register values; int_req uses the current global bit
  logic meas_d;
  logic irq_d;
  assign meas_d = ext_d[`WSC_BIT_MEAS];
  // Interrupt scope set by the global bit
  assign irq_d  = wake_event | (ext_q[`WSC_BIT_GLOBAL] & status_event);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      second_timer_wake_enable <= 1'b0;
      first_timer_wake_enable  <= 1'b0;
      input_a_wake_enable      <= 1'b1;
      input_b_wake_enable      <= 1'b1;
      input_c_wake_enable      <= 1'b1;
      measure_active           <= 1'b0;
      input_ab_level_ignore    <= 1'b0;
      input_a_pull_select      <= WSC_PULL_NONE;
      input_b_pull_select      <= WSC_PULL_NONE;
      input_c_pull_select      <= WSC_PULL_NONE;
      stop_watchdog_off        <= 1'b0;
      int_req                  <= 1'b0;
      bus_fail_safe_force      <= 1'b0;
      can_wake_source          <= 1'b0;
      lin_wake_source          <= 1'b0;
    end else if (ce) begin
      second_timer_wake_enable <= int_d[`WSC_BIT_T2_WAKE];
      first_timer_wake_enable  <= int_d[`WSC_BIT_T1_WAKE];
      input_a_wake_enable      <= ext_d[`WSC_BIT_A_WAKE] & ~meas_d;
      input_b_wake_enable      <= ext_d[`WSC_BIT_B_WAKE] & ~meas_d;
      input_c_wake_enable      <= ext_d[`WSC_BIT_C_WAKE];
      measure_active           <= meas_d & normal_mode;
      input_ab_level_ignore    <= meas_d;
      input_a_pull_select      <= wsc_pull_t'(pull_d[`WSC_POS_A_PULL +: 2]);
      input_b_pull_select      <= wsc_pull_t'(pull_d[`WSC_POS_B_PULL +: 2]);
      input_c_pull_select      <= wsc_pull_t'(pull_d[`WSC_POS_C_PULL +: 2]);
      // Off in stop mode only when both disable bits are set
      stop_watchdog_off        <= int_d[`WSC_BIT_WD_HI] & stop_watchdog_disable_lo;
      int_req                  <= irq_d;
      bus_fail_safe_force      <= fail_safe_entry & ~soft_reset;
      // Bus wake follows the bus control mode code, not this bank
      can_wake_source          <= (can_mode == `WSC_MODE_WAKE);
      lin_wake_source          <= (lin_mode == `WSC_MODE_WAKE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence write_ext_s;
    ce && wr_ok && frm_addr == `WSC_ADDR_EXT && !soft_reset && !restart_entry && !fail_safe_entry;
  endsequence
  sequence write_int_s;
    ce && wr_ok && frm_addr == `WSC_ADDR_INT && !soft_reset && !hw_stop_wd_upd;
  endsequence

  ext_write_a: assert property (write_ext_s |=> ext_q == ($past(frm_data) & 8'ha7))
    else $error("external register write mismatch");
  int_write_a: assert property (write_int_s |=> int_q == ($past(frm_data) & 8'hc4))
    else $error("internal register write mismatch");
  reserved_zero_a: assert property ((int_q & 8'h3b) == 8'h00 && (ext_q & 8'h58) == 8'h00
    && pull_q[7:6] == 2'h0)
    else $error("reserved bit set");
  no_frame_a: assert property (ce && !frm_valid && !soft_reset && !restart_entry && !fail_safe_entry
    && !hw_stop_wd_upd |=> $stable(int_q) && $stable(ext_q) && $stable(pull_q))
    else $error("register changed without frame");
  fail_safe_a: assert property (ce && fail_safe_entry && !soft_reset |=> ext_q[2:0] == 3'h7
    && ext_q[6] == 1'b0 && bus_fail_safe_force)
    else $error("fail-safe values not forced");
  soft_reset_a: assert property (ce && soft_reset |=> int_q == 8'h00 && ext_q == 8'h07
    && pull_q == 8'h00)
    else $error("soft reset values wrong");
  measure_mask_a: assert property (ce && ext_q[5] ##1 ce && ext_q[5] |-> !input_a_wake_enable
    && !input_b_wake_enable && input_ab_level_ignore)
    else $error("measure mode left wake enabled");
  hw_wd_a: assert property (ce && hw_stop_wd_upd && !soft_reset |=> int_q[2] == $past(hw_stop_wd_val))
    else $error("hardware watchdog bit update lost");
  irq_scope_a: assert property (ce && !wake_event && !ext_q[7] |=> !int_req)
    else $error("interrupt outside wake scope");
  irq_global_a: assert property (ce && status_event && ext_q[7] |=> int_req)
    else $error("global interrupt missed");
  timer_en_a: assert property (ce ##1 ce |-> second_timer_wake_enable == int_q[7]
    && first_timer_wake_enable == int_q[6])
    else $error("timer wake enable mismatch");
endmodule // wsc_regs

// File: verification/wsc_ctl_master.sv
// Serial control master model standing in for the controller on the register port
`timescale 1ns/1ps
module wsc_ctl_master (
  input  wire logic mclk,
  input  wire logic sdo,
  output logic      sclk,
  output logic      sdi,
  output logic      serial_chip_select_n
);
  // Idle: clock still, chip select high
  initial begin
    sclk = 1'b0;
    sdi = 1'b0;
    serial_chip_select_n = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One frame of nb bits, h cycles per clock phase; nb other than 16 is a bad frame
  task automatic xfer(input logic [6:0] a, input logic wr, input logic [7:0] d, input int nb, input int h,
                      output logic [7:0] q);
    logic [15:0] f;
    f = {d, wr, a};
    q = 8'h00;
    @(negedge mclk) serial_chip_select_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      @(negedge mclk);
      // Read data taken just before the rising clock
      if (i >= 8 && i < 16) q[i-8] = sdo;
      // Bits beyond a full frame are sent as ones
      sdi = (i < 16) ? f[i] : 1'b1;
      sclk = 1'b1;
      repeat (h) @(negedge mclk);
      sclk = 1'b0;
      repeat (h - 1) @(negedge mclk);
    end
    @(negedge mclk);
    serial_chip_select_n = 1'b1;
    // Released data line shows no stale value
    sdi = ~sdi;
    repeat (3) @(negedge mclk);
  endtask
endmodule // wsc_ctl_master

// File: verification/tb_wake_source_config_regs.sv
// Self-checking testbench of the wake source configuration register bank
`timescale 1ns/1ps
module tb_wake_source_config_regs import wsc_pkg::*;;
  logic      mclk = 1'b0, nrst = 1'b0, ce = 1'b1, soft_reset = 1'b0, restart_entry = 1'b0;
  logic      fail_safe_entry = 1'b0, normal_mode = 1'b0, wd_lo = 1'b0, hw_upd = 1'b0, hw_val = 1'b0;
  logic      wake_event = 1'b0, status_event = 1'b0;
  logic [1:0] can_mode = 2'h0, lin_mode = 2'h0;
  logic      sclk, sdi, chip_sel_n, sdo, oe, t2, t1, wa, wb, wc, meas, lvl_ign;
  logic      wd_off, int_req, bus_fs, can_wk, lin_wk;
  wsc_pull_t pa, pb, pc;
  int        err_count = 0, n_compared = 0;
  logic [7:0] q;
  // 20 MHz clock
  always #25 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////////
  wsc_regs dut_u (.mclk(mclk), .nrst(nrst), .ce(ce), .soft_reset(soft_reset), .restart_entry(restart_entry),
    .fail_safe_entry(fail_safe_entry), .normal_mode(normal_mode), .stop_watchdog_disable_lo(wd_lo),
    .hw_stop_wd_upd(hw_upd), .hw_stop_wd_val(hw_val), .wake_event(wake_event), .status_event(status_event),
    .can_mode(can_mode), .lin_mode(lin_mode), .sclk(sclk), .sdi(sdi), .serial_chip_select_n(chip_sel_n),
    .sdo(sdo), .sdo_oe(oe), .second_timer_wake_enable(t2), .first_timer_wake_enable(t1),
    .input_a_wake_enable(wa), .input_b_wake_enable(wb), .input_c_wake_enable(wc), .measure_active(meas),
    .input_ab_level_ignore(lvl_ign), .input_a_pull_select(pa), .input_b_pull_select(pb),
    .input_c_pull_select(pc), .stop_watchdog_off(wd_off), .int_req(int_req), .bus_fail_safe_force(bus_fs),
    .can_wake_source(can_wk), .lin_wake_source(lin_wk));
  wsc_ctl_master m_u (.mclk(mclk), .sdo(sdo), .sclk(sclk), .sdi(sdi), .serial_chip_select_n(chip_sel_n));
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Bus cycles: prompt writes, slow reads
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    m_u.xfer(a, 1'b1, d, 16, 2, q);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    fork
      m_u.xfer(a, 1'b0, 8'hff, 16, 3, q);
      begin
        // Data output enabled while the frame is open
        repeat (4) @(negedge mclk);
        chk8("output enable", 8'h01, {7'h0, oe});
      end
    join
    chk8("readback", e, q);
  endtask
  // One-cycle pulse: 0 restart, 1 hardware watchdog update, 2 soft reset
  task automatic pulse(input int w);
    @(negedge mclk);
    if (w == 0) restart_entry = 1'b1;
    else if (w == 1) hw_upd = 1'b1;
    else soft_reset = 1'b1;
    @(negedge mclk);
    restart_entry = 1'b0;
    hw_upd = 1'b0;
    soft_reset = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(7'h06, 8'h00);
    rd(7'h07, 8'h07);
    rd(7'h08, 8'h00);
    chk8("wake enables", 8'h07, {5'h0, wc, wb, wa});
    chk8("pulls", 8'h00, {2'h0, pc, pb, pa});
  endtask
  task automatic t_internal;
    wr(7'h06, 8'hff);
    rd(7'h06, 8'hc4);
    chk8("timers", 8'h03, {6'h0, t2, t1});
    wd_lo = 1'b1;
    repeat (2) @(negedge mclk);
    chk8("wd off", 8'h01, {7'h0, wd_off});
    wd_lo = 1'b0;
    repeat (2) @(negedge mclk);
    chk8("wd off lo", 8'h00, {7'h0, wd_off});
    wr(7'h06, 8'h40);
    chk8("timers 2", 8'h01, {6'h0, t2, t1});
    hw_val = 1'b1;
    pulse(1);
    rd(7'h06, 8'h44);
  endtask
  task automatic t_external;
    wr(7'h07, 8'hff);
    rd(7'h07, 8'ha7);
    chk8("meas enables", 8'h04, {5'h0, wc, wb, wa});
    chk8("level ignore", 8'h01, {7'h0, lvl_ign});
    chk8("meas idle", 8'h00, {7'h0, meas});
    normal_mode = 1'b1;
    repeat (2) @(negedge mclk);
    chk8("meas normal", 8'h01, {7'h0, meas});
    wr(7'h07, 8'h05);
    chk8("enables 5", 8'h05, {5'h0, wc, wb, wa});
    wr(7'h07, 8'h02);
    chk8("enables 2", 8'h02, {5'h0, wc, wb, wa});
    chk8("meas off", 8'h00, {6'h0, meas, lvl_ign});
    normal_mode = 1'b0;
  endtask
  task automatic t_pull;
    logic [1:0] k;
    for (int i = 0; i < 4; i++) begin
      k = i[1:0];
      wr(7'h08, {2'h3, k, ~k, k});
      rd(7'h08, {2'h0, k, ~k, k});
      chk8("pull fields", {2'h0, k, ~k, k}, {2'h0, pc, pb, pa});
    end
  endtask
  task automatic t_interrupt;
    wr(7'h07, 8'h00);
    @(negedge mclk) status_event = 1'b1;
    @(negedge mclk) chk8("int status", 8'h00, {7'h0, int_req});
    status_event = 1'b0;
    wake_event = 1'b1;
    @(negedge mclk) chk8("int wake", 8'h01, {7'h0, int_req});
    wake_event = 1'b0;
    wr(7'h07, 8'h80);
    @(negedge mclk) status_event = 1'b1;
    @(negedge mclk) chk8("int global", 8'h01, {7'h0, int_req});
    status_event = 1'b0;
  endtask
  task automatic t_failsafe;
    pulse(0);
    rd(7'h07, 8'h80);
    wr(7'h07, 8'ha0);
    @(negedge mclk) fail_safe_entry = 1'b1;
    @(negedge mclk) fail_safe_entry = 1'b0;
    chk8("bus force", 8'h01, {7'h0, bus_fs});
    rd(7'h07, 8'ha7);
    chk8("bus force end", 8'h00, {7'h0, bus_fs});
  endtask
  task automatic t_frames;
    m_u.xfer(7'h07, 1'b1, 8'h00, 15, 2, q);
    rd(7'h07, 8'ha7);
    m_u.xfer(7'h07, 1'b1, 8'h00, 17, 2, q);
    rd(7'h07, 8'ha7);
    wr(7'h05, 8'hff);
    rd(7'h05, 8'h00);
    chk8("output enable idle", 8'h00, {7'h0, oe});
  endtask
  task automatic t_bus;
    for (int i = 0; i < 4; i++) begin
      can_mode = i[1:0];
      lin_mode = ~i[1:0];
      repeat (2) @(negedge mclk);
      chk8("can wake", {7'h0, i == 1}, {7'h0, can_wk});
      chk8("lin wake", {7'h0, i == 2}, {7'h0, lin_wk});
    end
  endtask
  task automatic t_soft;
    wr(7'h06, 8'hc0);
    wr(7'h08, 8'h3f);
    pulse(2);
    rd(7'h06, 8'h00);
    rd(7'h07, 8'h07);
    rd(7'h08, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(negedge mclk);
    nrst = 1'b1;
    t_reset();
    t_internal();
    t_external();
    t_pull();
    t_interrupt();
    t_failsafe();
    t_frames();
    t_bus();
    t_soft();
    print_verdict();
  end
  // Hang limit
  initial begin
    #5000000;
    err_count++;
    print_verdict();
  end
endmodule // tb_wake_source_config_regs
